// ==== hdl/ccr_regs.sv ====
// Configuration and counter register bank reached by register index
// Contract
// - Identification leaf 1 loads update signature
// - No update loaded leaves signature unchanged (zero after a pre-zero)
// - Signature writes blocked during guest transfer
// - Monitor config: valid bit, segment base
// - Reference counter counts ticks in active
// - Reference cleared by write or wrap
// - Actual counter counts active core cycles
// - Actual cleared by write or wrap
// - Capability low byte gives variable ranges
// - Capability bit 8 flags fixed ranges
// - Capability bit 10 flags write combining
`timescale 1ns/1ps
module ccr_regs
    import ccr_pkg::*;
(
    // Clock and reset
    input  wire logic              core_clk_in,
    input  wire logic              sys_rst_in,
    // Register instruction port
    input  wire logic [31:0]       reg_index_in,
    input  wire logic              reg_wr_en_in,
    input  wire logic              reg_rd_en_in,
    input  wire logic [DATA_W-1:0] reg_wr_data_in,
    output logic      [DATA_W-1:0] reg_rd_data_out,
    output logic                   reg_rd_valid_out,
    output logic                   reg_fault_out,
    // Processor state
    input  wire logic              c0_active_in,
    input  wire logic              ref_tick_in,
    input  wire logic              guest_xfer_in,
    input  wire logic              ident_leaf1_in,
    // Microcode update status
    input  wire logic              update_loaded_in,
    input  wire logic [SIG_W-1:0]  update_sig_in,
    // Performance events, one per counter
    input  wire logic [NUM_PMC-1:0] perf_event_in,
    // Monitor configuration and fast system call selector seen by the core
    output logic                   smm_valid_out,
    output logic [SMM_BASE_W-1:0]  monitor_segment_base_out,
    output logic [SEL_W-1:0]       syscall_selector_out
);
    // Link to the frequency counter pair
    ccr_cnt_if cnt_link ();

    // Stored signature field
    logic [SIG_W-1:0]      sig_reg;
    logic [SIG_W-1:0]      sig_next;
    // Monitor configuration fields
    logic                  smm_valid_reg;
    logic [SMM_BASE_W-1:0] smm_base_reg;
    // Fast system call selector
    logic [SEL_W-1:0]      sel_reg;
    // General performance counters
    logic [DATA_W-1:0]     pmc_reg  [NUM_PMC];
    logic [DATA_W-1:0]     pmc_next [NUM_PMC];
    // Read return path
    logic [DATA_W-1:0]     rd_data_reg;
    logic                  rd_valid_reg;
    logic                  fault_reg;

    // Index decode, one wire per register
    logic hit_sig;    // Signature register selected
    logic hit_smm;    // Monitor configuration selected
    logic hit_pmc0;   // Counter 0 selected
    logic hit_pmc1;   // Counter 1 selected
    logic hit_ref;    // Reference-frequency counter selected
    logic hit_act;    // Actual-frequency counter selected
    logic hit_cap;    // Capability register selected
    logic hit_sel;    // Code selector selected
    logic hit_any;    // Any implemented index
    logic access;     // Read or write issued this cycle

    assign hit_sig  = (reg_index_in == IDX_SIGNATURE);
    assign hit_smm  = (reg_index_in == IDX_SMM_CFG);
    assign hit_pmc0 = (reg_index_in == IDX_PMC0);
    assign hit_pmc1 = (reg_index_in == IDX_PMC1);
    assign hit_ref  = (reg_index_in == IDX_REF_FREQ);
    assign hit_act  = (reg_index_in == IDX_ACT_FREQ);
    assign hit_cap  = (reg_index_in == IDX_RANGE_CAP);
    assign hit_sel  = (reg_index_in == IDX_SYSCALL);
    assign hit_any  = hit_sig | hit_smm | hit_pmc0 | hit_pmc1 |
                      hit_ref | hit_act | hit_cap | hit_sel;
    assign access   = reg_wr_en_in | reg_rd_en_in;

    // Write strobes per register
    logic wr_sig;     // Signature write accepted
    logic wr_smm;     // Monitor configuration write
    logic wr_sel;     // Selector write
    logic [NUM_PMC-1:0] wr_pmc;  // Counter writes
    // Writes to the capability register are ignored; it is read-only

    assign wr_sig    = reg_wr_en_in & hit_sig & ~guest_xfer_in;
    assign wr_smm    = reg_wr_en_in & hit_smm;
    assign wr_sel    = reg_wr_en_in & hit_sel;
    assign wr_pmc[0] = reg_wr_en_in & hit_pmc0;
    assign wr_pmc[1] = reg_wr_en_in & hit_pmc1;

    // Frequency counter controls
    assign cnt_link.c0_active = c0_active_in;
    assign cnt_link.ref_tick  = ref_tick_in;
    assign cnt_link.clr_ref   = reg_wr_en_in & hit_ref;
    assign cnt_link.clr_act   = reg_wr_en_in & hit_act;

    // Counter pair lives in its own module
    ccr_freq_counters u_freq
    (
        .core_clk_in (core_clk_in),
        .sys_rst_in  (sys_rst_in),
        .cnt         (cnt_link.cnt)
    );

    // Signature next value. The identification event wins over a
    // same-cycle software write, so a pre-zero cannot mask the result.
    // leaf 1 captures update signature
    assign sig_next = ident_leaf1_in ?
                      (update_loaded_in ? update_sig_in : sig_reg) :
                      wr_sig ? reg_wr_data_in[SIG_LSB +: SIG_W] : sig_reg;

    // Signature register
    always_ff @(posedge core_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            sig_reg <= ZERO_64[SIG_W-1:0];
        end
        else
        begin
            sig_reg <= sig_next;
        end
    end

    // Monitor configuration; reserved bits are not stored
    always_ff @(posedge core_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            smm_valid_reg <= 1'b0;
            smm_base_reg  <= ZERO_64[SMM_BASE_W-1:0];
        end
        else if (wr_smm)
        begin
            smm_valid_reg <= reg_wr_data_in[SMM_VALID_BIT];
            smm_base_reg  <= reg_wr_data_in[SMM_BASE_LSB +: SMM_BASE_W];
        end
    end

    // Fast system call code selector, low field only
    always_ff @(posedge core_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            sel_reg <= ZERO_64[SEL_W-1:0];
        end
        else if (wr_sel)
        begin
            sel_reg <= reg_wr_data_in[SEL_W-1:0];
        end
    end

    // General performance counters, one per generate entry.
    // A write in the same cycle as an event takes the written value;
    // the event is dropped, which matches a counter being reloaded.
    genvar gi;
    generate
        for (gi = 0; gi < NUM_PMC; gi++)
        begin : g_pmc
            assign pmc_next[gi] = wr_pmc[gi] ? reg_wr_data_in :
                                  perf_event_in[gi] ? pmc_reg[gi] + 64'h1 :
                                  pmc_reg[gi];

            // Counter storage
            always_ff @(posedge core_clk_in or posedge sys_rst_in)
            begin
                if (sys_rst_in)
                begin
                    pmc_reg[gi] <= ZERO_64;
                end
                else
                begin
                    pmc_reg[gi] <= pmc_next[gi];
                end
            end
        end
    endgenerate

    // Read views of each register, reserved bits as zero
    logic [DATA_W-1:0] view_sig;   // Signature view
    logic [DATA_W-1:0] view_smm;   // Monitor configuration view
    logic [DATA_W-1:0] view_cap;   // Capability view
    logic [DATA_W-1:0] view_sel;   // Selector view
    logic [DATA_W-1:0] rd_mux;     // Selected read value

    assign view_sig = {sig_reg, ZERO_64[SIG_LSB-1:0]};
    assign view_smm = {ZERO_64[DATA_W-1:SMM_BASE_LSB+SMM_BASE_W],
                       smm_base_reg,
                       ZERO_64[SMM_BASE_LSB-1:SMM_VALID_BIT+1],
                       smm_valid_reg};
    assign view_sel = {ZERO_64[DATA_W-1:SEL_W], sel_reg};
    assign view_cap = {ZERO_64[DATA_W-1:CAP_COMB_BIT+1],
                       CAP_COMB_SUP,
                       1'b0,
                       CAP_FIXED_SUP,
                       CAP_VAR_COUNT};

    // Read selection; unmapped indices return zero
    assign rd_mux = hit_sig  ? view_sig :
                    hit_smm  ? view_smm :
                    hit_pmc0 ? pmc_reg[0] :
                    hit_pmc1 ? pmc_reg[1] :
                    hit_ref  ? cnt_link.ref_count :
                    hit_act  ? cnt_link.act_count :
                    hit_cap  ? view_cap :
                    hit_sel  ? view_sel : ZERO_64;

    // Read data registered; returned one cycle after the request.
    // Counters are sampled before this cycle's update.
    always_ff @(posedge core_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            rd_data_reg  <= ZERO_64;
            rd_valid_reg <= 1'b0;
        end
        else
        begin
            rd_data_reg  <= reg_rd_en_in ? rd_mux : rd_data_reg;
            rd_valid_reg <= reg_rd_en_in;
        end
    end

    // Fault pulse for an unimplemented index, as the core would trap
    always_ff @(posedge core_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            fault_reg <= 1'b0;
        end
        else
        begin
            fault_reg <= access & ~hit_any;
        end
    end

    // Outputs
    assign reg_rd_data_out          = rd_data_reg;
    assign reg_rd_valid_out         = rd_valid_reg;
    assign reg_fault_out            = fault_reg;
    assign smm_valid_out            = smm_valid_reg;
    assign monitor_segment_base_out = smm_base_reg;
    assign syscall_selector_out     = sel_reg;
endmodule

// ==== shared/ccr_pkg.sv ====
// Package: register indices, field layouts and capability values
package ccr_pkg;
    // Register indices used by the register read and write instructions
    localparam logic [31:0] IDX_SIGNATURE = 32'h0000_008b;
    localparam logic [31:0] IDX_SMM_CFG   = 32'h0000_009b;
    localparam logic [31:0] IDX_PMC0      = 32'h0000_00c1;
    localparam logic [31:0] IDX_PMC1      = 32'h0000_00c2;
    localparam logic [31:0] IDX_REF_FREQ  = 32'h0000_00e7;
    localparam logic [31:0] IDX_ACT_FREQ  = 32'h0000_00e8;
    localparam logic [31:0] IDX_RANGE_CAP = 32'h0000_00fe;
    localparam logic [31:0] IDX_SYSCALL   = 32'h0000_0174;
    // Register width and counter count
    localparam int DATA_W  = 64;
    localparam int NUM_PMC = 2;
    // Signature field: upper half holds the loaded update signature
    localparam int SIG_LSB = 32;
    localparam int SIG_W   = 32;
    // Monitor configuration fields
    localparam int SMM_VALID_BIT = 0;
    localparam int SMM_BASE_LSB  = 12;
    localparam int SMM_BASE_W    = 20;
    // Code selector field
    localparam int SEL_W = 16;
    // Capability layout
    localparam int CAP_FIXED_BIT = 8;
    localparam int CAP_COMB_BIT  = 10;
    // Capability values of this processor
    localparam logic [7:0] CAP_VAR_COUNT = 8'h08;
    localparam logic       CAP_FIXED_SUP = 1'b1;
    localparam logic       CAP_COMB_SUP  = 1'b1;
    // Reset value and all-ones wrap compare value
    localparam logic [DATA_W-1:0] ZERO_64 = 64'h0000_0000_0000_0000;
    localparam logic [DATA_W-1:0] ONES_64 = 64'hffff_ffff_ffff_ffff;
endpackage

// ==== shared/ccr_cnt_if.sv ====
// Interface between the register bank and the frequency counter pair
`timescale 1ns/1ps
interface ccr_cnt_if;
    import ccr_pkg::*;
    logic              c0_active;  // Processor in active state
    logic              ref_tick;   // Reference rate tick
    logic              clr_ref;    // Software write clears reference count
    logic              clr_act;    // Software write clears actual count
    logic [DATA_W-1:0] ref_count;  // Reference-frequency count
    logic [DATA_W-1:0] act_count;  // Actual-frequency count
    // Bank side drives controls and reads counts
    modport bank (output c0_active, ref_tick, clr_ref, clr_act,
                  input  ref_count, act_count);
    // Counter side
    modport cnt  (input  c0_active, ref_tick, clr_ref, clr_act,
                  output ref_count, act_count);
endinterface

// ==== hdl/ccr_freq_counters.sv ====
// Reference- and actual-frequency counters that clear each other on wrap
`timescale 1ns/1ps
module ccr_freq_counters
    import ccr_pkg::*;
(
    // Clock and reset
    input  wire logic core_clk_in,
    input  wire logic sys_rst_in,
    // Bank side
    ccr_cnt_if.cnt    cnt
);
    logic [DATA_W-1:0] ref_reg;   // Reference-frequency count
    logic [DATA_W-1:0] act_reg;   // Actual-frequency count
    logic [DATA_W-1:0] ref_next;  // Next reference count
    logic [DATA_W-1:0] act_next;  // Next actual count
    logic              ref_inc;   // Reference counter steps this cycle
    logic              act_inc;   // Actual counter steps this cycle
    logic              ref_wrap;  // Reference counter rolls over
    logic              act_wrap;  // Actual counter rolls over

    assign ref_inc  = cnt.c0_active & cnt.ref_tick;
    // actual counts every active core cycle
    assign act_inc  = cnt.c0_active;
    assign ref_wrap = ref_inc & (ref_reg == ONES_64);
    assign act_wrap = act_inc & (act_reg == ONES_64);

    assign ref_next = (cnt.clr_ref | act_wrap) ? ZERO_64 :
                      ref_inc ? ref_reg + 64'h1 : ref_reg;
    assign act_next = (cnt.clr_act | ref_wrap) ? ZERO_64 :
                      act_inc ? act_reg + 64'h1 : act_reg;

    // Both counters update on the same clock edge so the ratio stays coherent
    always_ff @(posedge core_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            ref_reg <= ZERO_64;
            act_reg <= ZERO_64;
        end
        else
        begin
            ref_reg <= ref_next;
            act_reg <= act_next;
        end
    end

    assign cnt.ref_count = ref_reg;
    assign cnt.act_count = act_reg;
endmodule

// ==== tb/ccr_regs_asserts.sv ====
// Checker bound to the configuration and counter register bank
`timescale 1ns/1ps
module ccr_regs_asserts
    import ccr_pkg::*;
(
    // Clock and reset
    input wire logic                  core_clk_in,
    input wire logic                  sys_rst_in,
    // Register port
    input wire logic [31:0]           reg_index_in,
    input wire logic                  reg_wr_en_in,
    input wire logic                  reg_rd_en_in,
    input wire logic [DATA_W-1:0]     reg_wr_data_in,
    input wire logic [DATA_W-1:0]     reg_rd_data_out,
    input wire logic                  reg_rd_valid_out,
    input wire logic                  reg_fault_out,
    // Signature source and config outputs
    input wire logic                  ident_leaf1_in,
    input wire logic                  update_loaded_in,
    input wire logic [SIG_W-1:0]      update_sig_in,
    input wire logic                  smm_valid_out,
    input wire logic [SMM_BASE_W-1:0] monitor_segment_base_out
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (sys_rst_in);
    // Decode of the access, shared by the properties below
    wire mapped = reg_index_in inside {IDX_SIGNATURE, IDX_SMM_CFG, IDX_PMC0, IDX_PMC1,
        IDX_REF_FREQ, IDX_ACT_FREQ, IDX_RANGE_CAP, IDX_SYSCALL};
    wire unm    = (reg_rd_en_in | reg_wr_en_in) & !mapped;
    wire rd_sig = reg_rd_en_in && reg_index_in == IDX_SIGNATURE;
    wire rd_cap = reg_rd_en_in && reg_index_in == IDX_RANGE_CAP;
    wire wr_clr = reg_wr_en_in && (reg_index_in == IDX_REF_FREQ || reg_index_in == IDX_ACT_FREQ);
    wire wr_smm = reg_wr_en_in && reg_index_in == IDX_SMM_CFG;
    rd_valid_a: assert property (reg_rd_valid_out == $past(reg_rd_en_in))
        else $error("read valid does not follow read strobe");
    unmapped_fault_a: assert property (reg_fault_out == $past(unm))
        else $error("fault pulse wrong");
    unmapped_zero_a: assert property (reg_rd_en_in && !mapped |=> reg_rd_data_out == ZERO_64)
        else $error("unmapped read not zero");
    cap_value_a: assert property (rd_cap |=> reg_rd_data_out ==
        {53'h0, CAP_COMB_SUP, 1'b0, CAP_FIXED_SUP, CAP_VAR_COUNT})
        else $error("capability read wrong");
    sig_low_zero_a: assert property (rd_sig |=> reg_rd_data_out[31:0] == 32'h0)
        else $error("signature low half not zero");
    sig_load_a: assert property (ident_leaf1_in && update_loaded_in ##1 rd_sig
        |=> reg_rd_data_out[63:32] == $past(update_sig_in, 2))
        else $error("signature not loaded");
    rd_hold_a: assert property (!reg_rd_en_in |=> $stable(reg_rd_data_out))
        else $error("read data moved without read");
    count_clear_a: assert property (wr_clr ##1 reg_rd_en_in && reg_index_in ==
        $past(reg_index_in) |=> reg_rd_data_out == ZERO_64)
        else $error("counter not cleared by write");
    smm_out_a: assert property (wr_smm |=> smm_valid_out == $past(reg_wr_data_in[0]) &&
        monitor_segment_base_out == $past(reg_wr_data_in[31:12]))
        else $error("monitor config outputs wrong");
    // Main scenarios
    cover property (rd_cap ##1 reg_rd_valid_out);
    cover property (reg_fault_out);
    cover property (ident_leaf1_in && update_loaded_in ##1 rd_sig);
endmodule

bind ccr_regs ccr_regs_asserts u_ccr_regs_asserts (.core_clk_in, .sys_rst_in, .reg_index_in,
    .reg_wr_en_in, .reg_rd_en_in, .reg_wr_data_in, .reg_rd_data_out, .reg_rd_valid_out,
    .reg_fault_out, .ident_leaf1_in, .update_loaded_in, .update_sig_in, .smm_valid_out,
    .monitor_segment_base_out);

// ==== tb/tb.sv ====
// Self-checking bench for the configuration and counter register bank
`timescale 1ns/1ps
module tb
    import ccr_pkg::*;
;
    localparam logic [63:0] CAP_EXP = {53'h0, CAP_COMB_SUP, 1'b0, CAP_FIXED_SUP, CAP_VAR_COUNT};
    localparam logic [31:0] UPD_SIG = 32'h0000_0a5c; // Arbitrary update signature
    logic              core_clk_in, sys_rst_in, reg_wr_en_in, reg_rd_en_in, reg_rd_valid_out;
    logic              reg_fault_out, c0_active_in, ref_tick_in, guest_xfer_in;
    logic              ident_leaf1_in, update_loaded_in, smm_valid_out;
    logic [31:0]       reg_index_in;
    logic [63:0]       reg_wr_data_in, reg_rd_data_out;
    logic [SIG_W-1:0]  update_sig_in;
    logic [1:0]        perf_event_in;
    logic [19:0]       monitor_segment_base_out;
    logic [15:0]       syscall_selector_out;
    int                errors, checks;
    // Registers that read zero out of reset
    logic [31:0]       zero_tab [7] = '{IDX_SIGNATURE, IDX_SMM_CFG, IDX_PMC0, IDX_PMC1,
                                       IDX_REF_FREQ, IDX_ACT_FREQ, IDX_SYSCALL};

    ccr_regs u_ccr_regs (.core_clk_in, .sys_rst_in, .reg_index_in, .reg_wr_en_in,
        .reg_rd_en_in, .reg_wr_data_in, .reg_rd_data_out, .reg_rd_valid_out, .reg_fault_out,
        .c0_active_in, .ref_tick_in, .guest_xfer_in, .ident_leaf1_in, .update_loaded_in,
        .update_sig_in, .perf_event_in, .smm_valid_out, .monitor_segment_base_out,
        .syscall_selector_out);

    // Free-running core clock
    initial
    begin
        core_clk_in = 0;
        forever #4 core_clk_in = ~core_clk_in;
    end

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Strobes stay up so that two accesses can run back to back
    task automatic acc(input logic w, input logic [31:0] i, input logic [63:0] d);
        reg_wr_en_in = w;
        reg_rd_en_in = !w;
        reg_index_in = i;
        reg_wr_data_in = d;
        @(posedge core_clk_in);
        #1;
    endtask

    task automatic idle();
        reg_wr_en_in = 0;
        reg_rd_en_in = 0;
        @(posedge core_clk_in);
        #1;
    endtask

    task automatic wr(input logic [31:0] i, input logic [63:0] d);
        acc(1'b1, i, d);
        idle();
    endtask

    // Answer and fault are pulses, so look before dropping the strobe
    task automatic rd(input logic [31:0] i, input logic [63:0] exp, input logic flt = 1'b0);
        acc(1'b0, i, 64'h0);
        chk(reg_rd_data_out, exp);
        chk(reg_rd_valid_out, 1'b1);
        chk(reg_fault_out, flt);
        idle();
    endtask

    task automatic tally_and_finish();
        if (errors == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Run is about a hundred cycles; the limit is generous
    initial
    begin
        #100000;
        errors++;
        tally_and_finish();
    end

    initial
    begin
        {reg_wr_en_in, reg_rd_en_in, c0_active_in, ref_tick_in, guest_xfer_in} = 5'h00;
        {ident_leaf1_in, update_loaded_in, perf_event_in} = 4'h0;
        {reg_index_in, reg_wr_data_in, update_sig_in} = 128'h0;
        sys_rst_in = 1;
        repeat (10) @(posedge core_clk_in);
        #1 sys_rst_in = 0;
        foreach (zero_tab[k]) rd(zero_tab[k], 64'h0);
        // Capability ignores writes
        wr(IDX_RANGE_CAP, ONES_64);
        rd(IDX_RANGE_CAP, CAP_EXP);
        // Reserved bits read zero
        wr(IDX_SMM_CFG, ONES_64);
        chk({smm_valid_out, monitor_segment_base_out}, 21'h1f_ffff);
        rd(IDX_SMM_CFG, 64'h0000_0000_ffff_f001);
        wr(IDX_SYSCALL, ONES_64);
        chk(syscall_selector_out, 16'hffff);
        rd(IDX_SYSCALL, 64'h0000_0000_0000_ffff);
        // Counter 0 counts across the 32-bit boundary, counter 1 holds
        wr(IDX_PMC0, 64'h0000_0000_ffff_fffe);
        wr(IDX_PMC1, 64'h0123_4567_89ab_cdef);
        perf_event_in = 2'b01;
        repeat (3) @(posedge core_clk_in);
        #1 perf_event_in = 2'b00;
        rd(IDX_PMC0, 64'h0000_0001_0000_0001);
        rd(IDX_PMC1, 64'h0123_4567_89ab_cdef);
        // Unmapped index faults on read and write
        rd(32'h0000_0100, 64'h0, 1'b1);
        acc(1'b1, 32'h0000_0100, ONES_64);
        chk(reg_fault_out, 1'b1);
        idle();
        // Signature load, guest block, pre-zero, no update
        update_loaded_in = 1;
        update_sig_in = UPD_SIG;
        ident_leaf1_in = 1;
        @(posedge core_clk_in);
        #1 ident_leaf1_in = 0;
        rd(IDX_SIGNATURE, {UPD_SIG, 32'h0});
        guest_xfer_in = 1;
        wr(IDX_SIGNATURE, 64'h0);
        guest_xfer_in = 0;
        rd(IDX_SIGNATURE, {UPD_SIG, 32'h0});
        // Software pre-zeroes the field before identification
        wr(IDX_SIGNATURE, 64'h0);
        update_loaded_in = 0;
        ident_leaf1_in = 1;
        @(posedge core_clk_in);
        #1 ident_leaf1_in = 0;
        rd(IDX_SIGNATURE, 64'h0);
        // Sixteen active cycles, a tick on every fourth
        c0_active_in = 1;
        for (int k = 0; k < 16; k++)
        begin
            ref_tick_in = (k % 4 == 0);
            @(posedge core_clk_in);
            #1;
        end
        c0_active_in = 0;
        ref_tick_in = 0;
        rd(IDX_ACT_FREQ, 64'h10);
        rd(IDX_REF_FREQ, 64'h4);
        ref_tick_in = 1;
        repeat (5) @(posedge core_clk_in);
        #1 ref_tick_in = 0;
        rd(IDX_ACT_FREQ, 64'h10);
        rd(IDX_REF_FREQ, 64'h4);
        // Write clears, read right behind it
        acc(1'b1, IDX_ACT_FREQ, ONES_64);
        rd(IDX_ACT_FREQ, 64'h0);
        acc(1'b1, IDX_REF_FREQ, ONES_64);
        rd(IDX_REF_FREQ, 64'h0);
        tally_and_finish();
    end
endmodule
